// File: mcsd_pkg.sv
// Constants and shared types for the memory chip select decode block
package mcsd_pkg;

  // Steering control port width and contents
  localparam int unsigned STEER_W = 5;
  localparam logic [4:0] STEER_RST = 5'h00;

  // Steering control bit positions
  localparam int unsigned BIT_PROM_BOOT = 0; // Upper range from PROM
  localparam int unsigned BIT_FLASH_RD  = 1; // Flash read allowed
  localparam int unsigned BIT_FLASH_WR  = 2; // Flash write allowed
  localparam int unsigned BIT_RAM_RD    = 3; // RAM read allowed
  localparam int unsigned BIT_RAM_WR    = 4; // RAM write allowed

  // I/O address of the steering port, same for both processors
  localparam int unsigned IO_ADDR_W = 16;
  localparam logic [15:0] STEER_IO_ADDR = 16'h00F0;

  // Memory control outputs of one processor
  typedef struct packed {
    logic prom_ce;   // PROM chip enable
    logic prom_rd;   // PROM read strobe
    logic flash_ce;  // Flash chip enable
    logic flash_rd;  // Flash read strobe
    logic flash_wr;  // Flash write strobe
    logic ram_ce_lo; // RAM low byte enable
    logic ram_ce_hi; // RAM high byte enable
    logic ram_rd;    // RAM read strobe
    logic ram_wr;    // RAM write strobe
    logic pub_sel;   // Public memory select
  } mcsd_mem_s;

  localparam mcsd_mem_s MEM_IDLE = '0;

endpackage : mcsd_pkg

// File: mcsd_sub_port.sv
// Steering port and memory decode for one subordinate processor
`timescale 1ns/100ps
`default_nettype none
module mcsd_sub_port #(
  parameter logic [15:0] IO_ADDR = mcsd_pkg::STEER_IO_ADDR
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  // I/O write port
  input  wire logic        io_wr_in,
  input  wire logic [15:0] io_addr_in,
  input  wire logic [4:0]  io_data_in,
  // Memory bus cycle
  input  wire logic        cyc_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic        upper_hit_in,
  input  wire logic        low_hit_in,
  input  wire logic        ble_in,
  input  wire logic        bhe_in,
  // Memory controls and steering value
  output mcsd_pkg::mcsd_mem_s mem_out,
  output logic [4:0]       steer_out
);

  // Whole module state
  typedef struct packed {
    logic [4:0]          steer;
    mcsd_pkg::mcsd_mem_s mem;
  } mcsd_sub_s;

  mcsd_sub_s st_reg;  // Registered state
  mcsd_sub_s st_next; // Next state

  // Latch steering on port writes and decode the memory cycle
  always_comb begin
    logic rd_c;
    logic wr_c;
    logic pub;
    rd_c = cyc_in & rd_in;
    wr_c = cyc_in & wr_in;
    pub  = (rd_c | wr_c) & ~upper_hit_in & ~low_hit_in;
    st_next = st_reg;
    // A write to the port address replaces all five bits
    if (io_wr_in && (io_addr_in == IO_ADDR)) begin
      st_next.steer = io_data_in;
    end
    // Controls follow the settings held before this cycle
    st_next.mem = mcsd_pkg::MEM_IDLE;
    if (cyc_in && !pub) begin
      st_next.mem.prom_ce = upper_hit_in & st_reg.steer[mcsd_pkg::BIT_PROM_BOOT];
      st_next.mem.prom_rd = rd_c & upper_hit_in
                          & st_reg.steer[mcsd_pkg::BIT_PROM_BOOT];
      st_next.mem.flash_ce = upper_hit_in & ~st_reg.steer[mcsd_pkg::BIT_PROM_BOOT]
                           | upper_hit_in & wr_c & st_reg.steer[mcsd_pkg::BIT_FLASH_WR];
      st_next.mem.flash_rd = rd_c & upper_hit_in & st_reg.steer[mcsd_pkg::BIT_FLASH_RD];
      st_next.mem.flash_wr = wr_c & upper_hit_in & st_reg.steer[mcsd_pkg::BIT_FLASH_WR];
      st_next.mem.ram_ce_lo = low_hit_in & ble_in;
      st_next.mem.ram_ce_hi = low_hit_in & bhe_in;
      st_next.mem.ram_rd = rd_c & low_hit_in & st_reg.steer[mcsd_pkg::BIT_RAM_RD];
      st_next.mem.ram_wr = wr_c & low_hit_in & st_reg.steer[mcsd_pkg::BIT_RAM_WR];
    end
    st_next.mem.pub_sel = pub;
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg.steer <= mcsd_pkg::STEER_RST;
      st_reg.mem   <= mcsd_pkg::MEM_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mem_out   = st_reg.mem;
  assign steer_out = st_reg.steer;

endmodule // mcsd_sub_port
`default_nettype wire

// File: mcsd_top.sv
// Chip select and strobe decode for the three processors
`timescale 1ns/100ps
`default_nettype none
module mcsd_top #(
  parameter logic [15:0] IO_ADDR = mcsd_pkg::STEER_IO_ADDR
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,

  // System processor bus cycle
  input  wire logic        sys_cyc_in,
  input  wire logic        sys_rd_in,
  input  wire logic        sys_wr_in,
  input  wire logic        sys_upper_hit_in,
  input  wire logic        sys_mid_hit_in,
  input  wire logic        sys_low_hit_in,
  input  wire logic        sys_ble_in,
  input  wire logic        sys_bhe_in,

  // System processor enable settings
  input  wire logic        boot_installed_in,
  input  wire logic        prom_rd_en_in,
  input  wire logic        code_wr_en_in,
  input  wire logic        app_rd_en_in,
  input  wire logic        app_wr_en_in,
  input  wire logic        ram_rd_ovl_in,
  input  wire logic        ram_wr_ovl_in,

  // System processor memory controls
  output logic             sys_prom_ce_out,
  output logic             sys_prom_rd_out,
  output logic             sys_code_ce_out,
  output logic             sys_code_rd_out,
  output logic             sys_code_wr_out,
  output logic             sys_app_ce_out,
  output logic             sys_app_rd_out,
  output logic             sys_app_wr_out,
  output logic             sys_ram_ce_lo_out,
  output logic             sys_ram_ce_hi_out,
  output logic             sys_ram_rd_out,
  output logic             sys_ram_wr_out,
  output logic             sys_pub_sel_out,

  // I/O scan processor port write and cycle
  input  wire logic        scan_io_wr_in,
  input  wire logic [15:0] scan_io_addr_in,
  input  wire logic [4:0]  scan_io_data_in,
  input  wire logic        scan_cyc_in,
  input  wire logic        scan_rd_in,
  input  wire logic        scan_wr_in,
  input  wire logic        scan_upper_hit_in,
  input  wire logic        scan_low_hit_in,
  input  wire logic        scan_ble_in,
  input  wire logic        scan_bhe_in,

  // I/O scan processor memory controls
  output mcsd_pkg::mcsd_mem_s scan_mem_out,
  output logic [4:0]       scan_steer_out,

  // Comm processor port write and cycle
  input  wire logic        comm_io_wr_in,
  input  wire logic [15:0] comm_io_addr_in,
  input  wire logic [4:0]  comm_io_data_in,
  input  wire logic        comm_cyc_in,
  input  wire logic        comm_rd_in,
  input  wire logic        comm_wr_in,
  input  wire logic        comm_upper_hit_in,
  input  wire logic        comm_low_hit_in,
  input  wire logic        comm_ble_in,
  input  wire logic        comm_bhe_in,

  // Comm processor memory controls
  output mcsd_pkg::mcsd_mem_s comm_mem_out,
  output logic [4:0]       comm_steer_out
);

  // System processor control state
  typedef struct packed {
    logic prom_ce;   // PROM enable
    logic prom_rd;   // PROM read strobe
    logic code_ce;   // Code flash enable
    logic code_rd;   // Code flash read strobe
    logic code_wr;   // Code flash write strobe
    logic app_ce;    // Applications flash enable
    logic app_rd;    // Applications flash read strobe
    logic app_wr;    // Applications flash write strobe
    logic ram_ce_lo; // RAM low byte enable
    logic ram_ce_hi; // RAM high byte enable
    logic ram_rd;    // RAM read strobe
    logic ram_wr;    // RAM write strobe
    logic pub_sel;   // Public memory select
  } mcsd_sys_s;

  mcsd_sys_s st_reg;  // Registered controls
  mcsd_sys_s st_next; // Next controls

  // Decode one system processor cycle into memory controls.
  // Outputs are registered, so each control trails its cycle
  // inputs by one clock; this costs a cycle of latency but
  // keeps decode glitches off the memory pins.
  always_comb begin
    logic rd_c;     // Qualified read cycle
    logic wr_c;     // Qualified write cycle
    logic any_hit;  // Some private range hit
    logic app_off;  // Applications flash disabled
    logic ovl;      // RAM overlay of middle range
    logic lo_sel;   // RAM low byte select term
    logic hi_sel;   // RAM high byte select term
    rd_c    = sys_cyc_in & sys_rd_in;
    wr_c    = sys_cyc_in & sys_wr_in;
    any_hit = sys_upper_hit_in | sys_mid_hit_in | sys_low_hit_in;
    app_off = ~app_rd_en_in & ~app_wr_en_in;
    ovl     = ram_rd_ovl_in | ram_wr_ovl_in;
    lo_sel  = 1'b0;
    hi_sel  = 1'b0;
    st_next = '0;

    // Public bus takes every read or write cycle outside the ranges
    st_next.pub_sel = (rd_c | wr_c) & ~any_hit;

    // Private controls only inside a hitting cycle
    if (sys_cyc_in && any_hit) begin
      // PROM: boot from it, or fetch applications from it
      st_next.prom_ce = (sys_upper_hit_in & boot_installed_in
                         & prom_rd_en_in)
                      | (sys_mid_hit_in & app_off);
      st_next.prom_rd = rd_c & st_next.prom_ce;

      // Code flash: run from it, or program it from PROM
      st_next.code_ce = sys_upper_hit_in
                      & (~boot_installed_in
                         | code_wr_en_in);
      st_next.code_wr = wr_c & sys_upper_hit_in & code_wr_en_in;

      // Applications flash: gated per direction
      st_next.app_ce = sys_mid_hit_in
                     & ((rd_c & app_rd_en_in)
                        | (wr_c & app_wr_en_in));
      st_next.app_rd = rd_c & st_next.app_ce & app_rd_en_in;
      st_next.app_wr = wr_c & st_next.app_ce & app_wr_en_in;

      // RAM byte enables: normal low memory or overlay.
      // Overlay may coexist with applications flash enable;
      // software must not enable both for the same direction.
      lo_sel = sys_low_hit_in | (sys_mid_hit_in & ovl);
      hi_sel = lo_sel;
      st_next.ram_ce_lo = lo_sel & sys_ble_in;
      st_next.ram_ce_hi = hi_sel & sys_bhe_in;

      // RAM strobes per direction
      st_next.ram_rd = rd_c & (sys_low_hit_in
                               | (sys_mid_hit_in & ram_rd_ovl_in));
      st_next.ram_wr = wr_c & (sys_low_hit_in
                               | (sys_mid_hit_in & ram_wr_ovl_in));
    end

    // Code flash read strobe follows every read cycle, even
    // public ones; its chip enable keeps the flash quiet.
    st_next.code_rd = rd_c;
  end

  // Control register, cleared to all inactive on reset
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs taken straight from the control register
  assign sys_prom_ce_out   = st_reg.prom_ce;
  assign sys_prom_rd_out   = st_reg.prom_rd;
  assign sys_code_ce_out   = st_reg.code_ce;
  assign sys_code_rd_out   = st_reg.code_rd;
  assign sys_code_wr_out   = st_reg.code_wr;
  assign sys_app_ce_out    = st_reg.app_ce;
  assign sys_app_rd_out    = st_reg.app_rd;
  assign sys_app_wr_out    = st_reg.app_wr;
  assign sys_ram_ce_lo_out = st_reg.ram_ce_lo;
  assign sys_ram_ce_hi_out = st_reg.ram_ce_hi;
  assign sys_ram_rd_out    = st_reg.ram_rd;
  assign sys_ram_wr_out    = st_reg.ram_wr;
  assign sys_pub_sel_out   = st_reg.pub_sel;

  // I/O scan processor steering port and decode
  mcsd_sub_port #(
    .IO_ADDR (IO_ADDR)
  ) u_scan (
    .ref_clk_in   (ref_clk_in),
    .rstn_in      (rstn_in),
    .io_wr_in     (scan_io_wr_in),
    .io_addr_in   (scan_io_addr_in),
    .io_data_in   (scan_io_data_in),
    .cyc_in       (scan_cyc_in),
    .rd_in        (scan_rd_in),
    .wr_in        (scan_wr_in),
    .upper_hit_in (scan_upper_hit_in),
    .low_hit_in   (scan_low_hit_in),
    .ble_in       (scan_ble_in),
    .bhe_in       (scan_bhe_in),
    .mem_out      (scan_mem_out),
    .steer_out    (scan_steer_out)
  );

  // Comm processor steering port and decode; an identical
  // port so both processors share one driver routine
  mcsd_sub_port #(
    .IO_ADDR (IO_ADDR)
  ) u_comm (
    .ref_clk_in   (ref_clk_in),
    .rstn_in      (rstn_in),
    .io_wr_in     (comm_io_wr_in),
    .io_addr_in   (comm_io_addr_in),
    .io_data_in   (comm_io_data_in),
    .cyc_in       (comm_cyc_in),
    .rd_in        (comm_rd_in),
    .wr_in        (comm_wr_in),
    .upper_hit_in (comm_upper_hit_in),
    .low_hit_in   (comm_low_hit_in),
    .ble_in       (comm_ble_in),
    .bhe_in       (comm_bhe_in),
    .mem_out      (comm_mem_out),
    .steer_out    (comm_steer_out)
  );

endmodule // mcsd_top
`default_nettype wire

// File: mcsd_top_props.sv
// Assertion checker for the chip select decode top
`timescale 1ns/100ps
`default_nettype none
module mcsd_top_props (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // System cycle and settings
  input wire logic sys_cyc_in,
  input wire logic sys_rd_in,
  input wire logic sys_wr_in,
  input wire logic sys_upper_hit_in,
  input wire logic sys_mid_hit_in,
  input wire logic sys_low_hit_in,
  input wire logic sys_ble_in,
  input wire logic boot_installed_in,
  input wire logic prom_rd_en_in,
  input wire logic app_rd_en_in,
  input wire logic app_wr_en_in,
  // System memory controls
  input wire logic sys_prom_ce_out,
  input wire logic sys_prom_rd_out,
  input wire logic sys_code_ce_out,
  input wire logic sys_code_rd_out,
  input wire logic sys_app_ce_out,
  input wire logic sys_app_rd_out,
  input wire logic sys_ram_ce_lo_out,
  input wire logic sys_pub_sel_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // Middle range read with applications reads on
  sequence s_mid_rd;
    sys_cyc_in && sys_rd_in && sys_mid_hit_in && app_rd_en_in;
  endsequence
  // Applications enable and strobe together
  sequence s_app_rd;
    sys_app_ce_out && sys_app_rd_out;
  endsequence
  AST_PROM_UP: assert property (sys_cyc_in && sys_upper_hit_in && boot_installed_in
    && prom_rd_en_in |=> sys_prom_ce_out) else $error("prom enable missing on upper boot");
  AST_PROM_MID: assert property (sys_cyc_in && sys_mid_hit_in && !app_rd_en_in
    && !app_wr_en_in |=> sys_prom_ce_out) else $error("prom enable missing on middle range");
  AST_PROM_RD: assert property (sys_prom_rd_out |-> sys_prom_ce_out && $past(sys_rd_in))
    else $error("prom read strobe without enable or read");
  AST_CODE_CE: assert property (sys_cyc_in && sys_upper_hit_in && !boot_installed_in
    |=> sys_code_ce_out) else $error("code flash enable missing");
  AST_CODE_RD: assert property (sys_cyc_in && sys_rd_in |=> sys_code_rd_out)
    else $error("code flash read strobe missing");
  AST_APP_RD: assert property (s_mid_rd |=> s_app_rd)
    else $error("applications flash read controls missing");
  AST_RAM_LO: assert property (sys_cyc_in && sys_low_hit_in && sys_ble_in
    |=> sys_ram_ce_lo_out) else $error("low byte ram enable missing");
  AST_PUB: assert property (sys_cyc_in && (sys_rd_in || sys_wr_in) && !sys_upper_hit_in
    && !sys_mid_hit_in && !sys_low_hit_in |=> sys_pub_sel_out && !sys_prom_ce_out
    && !sys_code_ce_out && !sys_app_ce_out && !sys_ram_ce_lo_out)
    else $error("public select wrong or private enable active");
endmodule // mcsd_top_props
bind mcsd_top mcsd_top_props props_u (.*);
`default_nettype wire

// File: mcsd_proc_model.sv
// Subordinate processor bus model driving one steering port and memory cycle
`timescale 1ns/100ps
`default_nettype none
module mcsd_proc_model (
  // Packed bus: io_wr, io_addr, io_data, cyc, rd, wr, upper, low, ble, bhe
  output var logic [28:0] bus_out
);
  initial bus_out = '0;
  // Place one bus state; caller times it just after a rising edge
  task automatic put(input logic [28:0] v);
    // Without an I/O write the address and data lines are not held
    if (!v[28]) v[27:7] = ~bus_out[27:7];
    bus_out = v;
  endtask
endmodule // mcsd_proc_model
`default_nettype wire

// File: mcsd_top_tb.sv
// Self-checking testbench for the chip select decode top
`timescale 1ns/100ps
`default_nettype none
module mcsd_top_tb;
  logic                ref_clk_in = 1'b0; // 50 MHz clock
  logic                rstn_in = 1'b0;    // Active low reset
  logic [14:0]         sv = '0;           // System cycle and settings
  logic [28:0]         sb, cb;            // Subordinate buses from the models
  wire logic [12:0]    so;                // System memory controls
  mcsd_pkg::mcsd_mem_s sm, cm;            // Subordinate memory controls
  logic [4:0]          sst, cst;          // Latched steering values
  logic [31:0]         seed = 32'hE8CC45C0;
  int                  bad_count = 0;
  int                  checked = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  mcsd_proc_model scan_u (.bus_out(sb));
  mcsd_proc_model comm_u (.bus_out(cb));
  mcsd_top dut_u (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .sys_cyc_in(sv[14]), .sys_rd_in(sv[13]), .sys_wr_in(sv[12]), .sys_upper_hit_in(sv[11]),
    .sys_mid_hit_in(sv[10]), .sys_low_hit_in(sv[9]), .sys_ble_in(sv[8]), .sys_bhe_in(sv[7]),
    .boot_installed_in(sv[6]), .prom_rd_en_in(sv[5]), .code_wr_en_in(sv[4]),
    .app_rd_en_in(sv[3]), .app_wr_en_in(sv[2]), .ram_rd_ovl_in(sv[1]), .ram_wr_ovl_in(sv[0]),
    .sys_prom_ce_out(so[12]), .sys_prom_rd_out(so[11]), .sys_code_ce_out(so[10]),
    .sys_code_rd_out(so[9]), .sys_code_wr_out(so[8]), .sys_app_ce_out(so[7]),
    .sys_app_rd_out(so[6]), .sys_app_wr_out(so[5]), .sys_ram_ce_lo_out(so[4]),
    .sys_ram_ce_hi_out(so[3]), .sys_ram_rd_out(so[2]), .sys_ram_wr_out(so[1]),
    .sys_pub_sel_out(so[0]),
    .scan_io_wr_in(sb[28]), .scan_io_addr_in(sb[27:12]), .scan_io_data_in(sb[11:7]),
    .scan_cyc_in(sb[6]), .scan_rd_in(sb[5]), .scan_wr_in(sb[4]), .scan_upper_hit_in(sb[3]),
    .scan_low_hit_in(sb[2]), .scan_ble_in(sb[1]), .scan_bhe_in(sb[0]),
    .scan_mem_out(sm), .scan_steer_out(sst),
    .comm_io_wr_in(cb[28]), .comm_io_addr_in(cb[27:12]), .comm_io_data_in(cb[11:7]),
    .comm_cyc_in(cb[6]), .comm_rd_in(cb[5]), .comm_wr_in(cb[4]), .comm_upper_hit_in(cb[3]),
    .comm_low_hit_in(cb[2]), .comm_ble_in(cb[1]), .comm_bhe_in(cb[0]),
    .comm_mem_out(cm), .comm_steer_out(cst)
  );
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // One range hit at most, read or write exclusive, so the decode is unambiguous
  function automatic logic [14:0] rnd_sys();
    logic [2:0] h;
    seed = xs(seed);
    h = (seed[4:3] == 2'h0) ? 3'h0 : 3'h1 << (2'h3 - seed[4:3]);
    return {seed[0] | seed[1], seed[2], !seed[2], h, seed[6:5], seed[13:7]};
  endfunction
  // Half the writes hit the port, with all-ones data as a corner value
  function automatic logic [28:0] rnd_sub();
    seed = xs(seed);
    return {seed[14], seed[15] ? mcsd_pkg::STEER_IO_ADDR : seed[31:16],
            seed[31] ? 5'h1F : seed[20:16], seed[21] | seed[22], seed[23], !seed[23],
            seed[25:24] == 2'h1, seed[25], seed[27:26]};
  endfunction
  // Expected system controls, same bit order as so
  function automatic logic [12:0] exp_sys(input logic [14:0] v);
    logic c, r, w, u, m, l, be, bh, bt, pr, cw, ar, aw, ro, wo, pe, ae;
    {c, r, w, u, m, l, be, bh, bt, pr, cw, ar, aw, ro, wo} = v;
    {r, w, u, m, l, be, bh} = {r, w, u, m, l, be, bh} & {7{c}};
    pe = (u & bt & pr) | (m & !ar & !aw);
    ae = m & ((r & ar) | (w & aw));
    return {pe, r & pe, u & (!bt | cw), r, w & u & cw, ae, r & ae & ar, w & ae & aw,
            be & (l | m & (ro | wo)), bh & (l | m & (ro | wo)), r & (l | m & ro),
            w & (l | m & wo), (r | w) & !u & !m & !l};
  endfunction
  // Expected subordinate controls from the bus and steering value
  function automatic mcsd_pkg::mcsd_mem_s exp_sub(input logic [28:0] b, input logic [4:0] s);
    logic r, w, u, l;
    mcsd_pkg::mcsd_mem_s e;
    {r, w, u, l} = b[5:2] & {4{b[6]}};
    e.prom_ce = u & s[0];
    e.prom_rd = r & e.prom_ce;
    e.flash_ce = u & (!s[0] | (w & s[2]));
    e.flash_rd = r & u & s[1];
    e.flash_wr = w & u & s[2];
    e.ram_ce_lo = l & b[1];
    e.ram_ce_hi = l & b[0];
    e.ram_rd = r & l & s[3];
    e.ram_wr = w & l & s[4];
    e.pub_sel = (r | w) & !u & !l;
    return e;
  endfunction
  // Compare one result; widths padded to 13 bits
  task automatic cmp(input string nm, input logic [12:0] e, input logic [12:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Random cycles on all three buses, one reset in mid-run
  initial begin
    logic [12:0] es;
    mcsd_pkg::mcsd_mem_s em, ec;
    logic [4:0] ms, mc;
    logic [28:0] sbv, cbv; // Bus states placed this cycle, read without a port delay
    ms = 5'h00;
    mc = 5'h00;
    repeat (5) @(posedge ref_clk_in);
    #1 rstn_in = 1'b1;
    for (int i = 0; i < 4000; i++) begin
      sv = rnd_sys();
      sbv = rnd_sub();
      cbv = rnd_sub();
      // The port nets settle a delta later, so expectations use the local copies
      scan_u.put(sbv);
      comm_u.put(cbv);
      if (i == 2000) rstn_in = 1'b0;
      es = exp_sys(sv);
      em = exp_sub(sbv, ms);
      ec = exp_sub(cbv, mc);
      if (sbv[28] && sbv[27:12] === mcsd_pkg::STEER_IO_ADDR) ms = sbv[11:7];
      if (cbv[28] && cbv[27:12] === mcsd_pkg::STEER_IO_ADDR) mc = cbv[11:7];
      @(posedge ref_clk_in);
      #1;
      // Reset clears everything and drops any write at that edge
      if (!rstn_in) begin
        {es, em, ec, ms, mc} = '0;
      end
      cmp("sys_controls", es, so);
      cmp("scan_controls", {3'h0, em}, {3'h0, sm});
      cmp("comm_controls", {3'h0, ec}, {3'h0, cm});
      cmp("scan_steer", {8'h00, ms}, {8'h00, sst});
      cmp("comm_steer", {8'h00, mc}, {8'h00, cst});
      if (!rstn_in) rstn_in = 1'b1;
    end
    wrap_up();
  end
endmodule // mcsd_top_tb
`default_nettype wire
